// ---- hdl/dcir_router.sv ----
`timescale 1ns/1ps
// Summary of operation
// - 147 sources; source n drives main-core request line n unchanged.
// - Secondary core has 32 request lines, each fed by one selected source.
// - Priority per interrupt: eight levels main core, four levels secondary.
// - Each core has one selectable source driving its non-maskable input.
// - Up to 41 designated sources wake the device from deep sleep.
// - Each core has its own vectored controller and wakeup controller path.
// - A system function start raises the secondary core's non-maskable input.
module dcir_router
    import dcir_pkg::*;
#(
    parameter int NUM_SRC = DCIR_NUM_SRC,
    parameter int SEC_LINES = DCIR_SEC_LINES,
    parameter int WAKE_SRC = DCIR_WAKE_SRC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // interrupt sources
    input wire logic [NUM_SRC-1:0] src_irq,
    // configuration of the main core
    input wire logic [NUM_SRC*DCIR_MAIN_PRIO_W-1:0] main_prio_cfg,
    input wire dcir_nmi_sel_s main_nmi_cfg,
    // configuration of the secondary core
    input wire dcir_sec_map_s [SEC_LINES-1:0] sec_map_cfg,
    input wire dcir_nmi_sel_s sec_nmi_cfg,
    // wakeup configuration and deep sleep state
    input wire logic [WAKE_SRC-1:0] wake_en_cfg,
    input wire logic deep_sleep,
    // system function start requests and completion
    input wire logic sysfn_main_req,
    input wire logic sysfn_sec_req,
    input wire logic sysfn_debug_access_port_req,
    input wire logic sysfn_done,
    // main core outputs
    output logic [NUM_SRC-1:0] main_numbered_request_line,
    output logic [NUM_SRC*DCIR_MAIN_PRIO_W-1:0] main_prio,
    output logic main_nmi,
    output logic main_wakeup,
    // secondary core outputs
    output logic [SEC_LINES-1:0] sec_numbered_request_line,
    output logic [SEC_LINES*DCIR_SEC_PRIO_W-1:0] sec_prio,
    output logic sec_nmi,
    output logic sec_wakeup,
    output logic sysfn_busy
);

    ////////////////////////////////////////////////////////////////////////
    // selection of secondary lines and both non-maskable sources

    logic [SEC_LINES-1:0] sec_hit;
    logic main_nmi_hit;
    logic sec_nmi_hit;
    logic [WAKE_SRC-1:0] wake_hit;
    logic wake_any;

    // one mux per secondary line; out-of-range codes read low
    genvar gi;
    generate
        for (gi = 0; gi < SEC_LINES; gi++) begin : g_sec
            dcir_src_mux #(.NUM_SRC(NUM_SRC)) u_mux (
                .src_vec(src_irq),
                .sel(sec_map_cfg[gi].src),
                .hit(sec_hit[gi])
            );
        end
    endgenerate

    dcir_src_mux #(.NUM_SRC(NUM_SRC)) u_main_nmi (
        .src_vec(src_irq),
        .sel(main_nmi_cfg.src),
        .hit(main_nmi_hit)
    );

    dcir_src_mux #(.NUM_SRC(NUM_SRC)) u_sec_nmi (
        .src_vec(src_irq),
        .sel(sec_nmi_cfg.src),
        .hit(sec_nmi_hit)
    );

    // only the low sources are wired into the wakeup path; higher sources can never
    // wake the device, whatever software writes into their enables
    generate
        for (gi = 0; gi < WAKE_SRC; gi++) begin : g_wake
            assign wake_hit[gi] = src_irq[gi] & wake_en_cfg[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // main core request lines and priorities

    // straight one-to-one registering, no remapping
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            main_numbered_request_line <= '0;
        end else begin
            main_numbered_request_line <= src_irq;
        end
    end

    // priorities travel with the lines so the controllers see them aligned
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            main_prio <= '0;
        end else begin
            main_prio <= main_prio_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // secondary core request lines and priorities

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sec_numbered_request_line <= '0;
        end else begin
            sec_numbered_request_line <= sec_hit;
        end
    end

    // four levels only, so the field is two bits wide
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sec_prio <= '0;
        end else begin
            for (int i = 0; i < SEC_LINES; i++) begin
                sec_prio[i*DCIR_SEC_PRIO_W +: DCIR_SEC_PRIO_W] <= sec_map_cfg[i].prio;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system function request state

    dcir_sf_state_e sf_state_ff;
    dcir_sf_state_e nxt_sf_state;
    logic sf_start;

    // any of the three requesters may start a system function, with no arbitration
    assign sf_start = sysfn_main_req | sysfn_sec_req | sysfn_debug_access_port_req;

    // a new start wins over a completion in the same cycle, so no request is lost
    always_comb begin
        nxt_sf_state = sf_state_ff;
        unique case (sf_state_ff)
            DCIR_SF_IDLE: begin
                if (sf_start) begin
                    nxt_sf_state = DCIR_SF_BUSY;
                end
            end
            DCIR_SF_BUSY: begin
                if (sysfn_done && !sf_start) begin
                    nxt_sf_state = DCIR_SF_IDLE;
                end
            end
            default: nxt_sf_state = DCIR_SF_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sf_state_ff <= DCIR_SF_IDLE;
        end else begin
            sf_state_ff <= nxt_sf_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sysfn_busy <= 1'h0;
        end else begin
            sysfn_busy <= (nxt_sf_state == DCIR_SF_BUSY);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // non-maskable outputs

    // main core: one enabled selection, nothing else can raise it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            main_nmi <= 1'h0;
        end else begin
            main_nmi <= main_nmi_cfg.enable & main_nmi_hit;
        end
    end

    // secondary core also takes system functions; uses the next state so the
    // request shows one cycle after the start, same as the selected source
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sec_nmi <= 1'h0;
        end else begin
            sec_nmi <= (sec_nmi_cfg.enable & sec_nmi_hit)
                | (nxt_sf_state == DCIR_SF_BUSY);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wakeup controllers, one per core

    // one shared qualified set feeds both controllers; a per-core mask would need a port
    assign wake_any = deep_sleep & (|wake_hit);

    // main core wakeup controller; only active while the vectored controllers are unclocked
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            main_wakeup <= 1'h0;
        end else begin
            main_wakeup <= wake_any;
        end
    end

    // secondary core wakeup controller, kept apart so each core wakes on its own flop
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sec_wakeup <= 1'h0;
        end else begin
            sec_wakeup <= wake_any;
        end
    end

endmodule

// ---- hdl/dcir_pkg.sv ----
package dcir_pkg;

    // source and line counts
    localparam int DCIR_NUM_SRC = 147;
    localparam int DCIR_SEC_LINES = 32;
    localparam int DCIR_WAKE_SRC = 41;
    localparam int DCIR_SEL_W = 8;
    localparam int DCIR_MAIN_PRIO_W = 3;
    localparam int DCIR_SEC_PRIO_W = 2;

    // selection value that maps nothing; any code at or above the source count is empty
    localparam logic [DCIR_SEL_W-1:0] DCIR_SEL_NONE = 8'hff;

    // per-line mapping of the secondary core: source and priority
    typedef struct packed {
        logic [DCIR_SEL_W-1:0] src;
        logic [DCIR_SEC_PRIO_W-1:0] prio;
    } dcir_sec_map_s;

    // non-maskable selection of one core
    typedef struct packed {
        logic enable;
        logic [DCIR_SEL_W-1:0] src;
    } dcir_nmi_sel_s;

    // state of the system function request
    typedef enum logic [1:0] {
        DCIR_SF_IDLE = 2'b00,
        DCIR_SF_BUSY = 2'b01
    } dcir_sf_state_e;

endpackage

// ---- hdl/dcir_src_mux.sv ----
`timescale 1ns/1ps
// picks one source out of the source vector; out-of-range codes give zero
module dcir_src_mux
    import dcir_pkg::*;
#(
    parameter int NUM_SRC = DCIR_NUM_SRC
) (
    // source vector and selection
    input wire logic [NUM_SRC-1:0] src_vec,
    input wire logic [DCIR_SEL_W-1:0] sel,
    // selected level
    output logic hit
);

    // a code past the last source must read low, not wrap
    always_comb begin
        hit = 1'h0;
        if (32'(sel) < NUM_SRC) begin
            hit = src_vec[sel];
        end
    end

endmodule

// ---- verification/dcir_props.sv ----
`timescale 1ns/1ps
module dcir_props
    import dcir_pkg::*;
(
    // clock, reset, inputs
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [146:0] src_irq,
    input wire dcir_nmi_sel_s main_nmi_cfg,
    input wire dcir_sec_map_s [31:0] sec_map_cfg,
    input wire logic sysfn_main_req,
    input wire logic sysfn_done,
    input wire logic sysfn_sec_req,
    input wire logic sysfn_debug_access_port_req,
    input wire logic deep_sleep,
    // outputs
    input wire logic [146:0] main_numbered_request_line,
    input wire logic main_nmi,
    input wire logic main_wakeup,
    input wire logic sec_wakeup,
    input wire logic [31:0] sec_numbered_request_line,
    input wire logic sec_nmi,
    input wire logic sysfn_busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic up_ff;
    logic [31:0] sec_exp;
    // masks the first edge after reset, when outputs still hold reset zeros
    always_ff @(posedge core_clk) up_ff <= rst_n;
    // codes past the last source must read as a quiet line
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            sec_exp[i] = sec_map_cfg[i].src < 8'h93 && src_irq[sec_map_cfg[i].src];
        end
    end
    a_main_copy: assert property (
        up_ff |-> main_numbered_request_line == $past(src_irq)) else $error("main copy");
    a_sec_map: assert property (
        up_ff |-> sec_numbered_request_line == $past(sec_exp)) else $error("sec map");
    a_sec_null: assert property (
        sec_map_cfg[0].src > 8'h92 |=> !sec_numbered_request_line[0]) else $error("sec null");
    a_nmi_pick: assert property (
        main_nmi_cfg.enable && main_nmi_cfg.src < 8'h93
        |=> main_nmi == $past(src_irq[main_nmi_cfg.src])) else $error("nmi pick");
    a_nmi_off: assert property (
        !main_nmi_cfg.enable |=> !main_nmi) else $error("nmi off");
    a_wake_pair: assert property (
        main_wakeup == sec_wakeup) else $error("wake pair");
    a_sysfn_start: assert property (
        sysfn_main_req |=> sysfn_busy && sec_nmi) else $error("sysfn start");
    a_busy_hold: assert property (
        sysfn_busy && !sysfn_done |=> sysfn_busy) else $error("busy hold");
    a_sysfn_other: assert property (
        sysfn_sec_req || sysfn_debug_access_port_req |=> sysfn_busy && sec_nmi)
        else $error("sysfn other");
    a_busy_end: assert property (
        sysfn_busy && sysfn_done && !sysfn_main_req && !sysfn_sec_req
        && !sysfn_debug_access_port_req |=> !sysfn_busy) else $error("busy end");
    a_wake_quiet: assert property (
        !deep_sleep |=> !main_wakeup && !sec_wakeup) else $error("wake quiet");
endmodule

// ---- verification/dcir_core_model.sv ----
`timescale 1ns/1ps
module dcir_core_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // entry and run length
    input wire logic sec_nmi,
    input wire logic [2:0] lat,
    // completion
    output logic sysfn_done
);
    logic [3:0] cnt_ff;
    // random lat gives both prompt and slow completions
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_ff <= 4'h0;
            sysfn_done <= 1'h0;
        end else begin
            sysfn_done <= cnt_ff == 4'h1;
            if (cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
            end else if (sec_nmi && !sysfn_done) begin
                cnt_ff <= {1'h0, lat} + 4'h1;
            end
        end
    end
endmodule

// ---- verification/dcir_router_bench.sv ----
`timescale 1ns/1ps
module dcir_router_bench
    import dcir_pkg::*;
;
    logic core_clk = 1'h0, rst_n = 1'h0, deep_sleep = 1'h0, sysfn_done, live = 1'h0;
    logic sysfn_main_req = 1'h0, sysfn_sec_req = 1'h0, sysfn_debug_access_port_req = 1'h0;
    logic [146:0] src_irq = '0, main_numbered_request_line, e_main;
    logic [440:0] main_prio_cfg = '0, main_prio, e_prio, r;
    logic [40:0] wake_en_cfg = '0;
    logic [63:0] sec_prio, e_sprio;
    logic [31:0] sec_numbered_request_line, e_sec;
    logic [2:0] lat = 3'h0;
    logic main_nmi, main_wakeup, sec_nmi, sec_wakeup, sysfn_busy, e_mnmi, e_snmi, e_wake, e_busy;
    dcir_nmi_sel_s main_nmi_cfg = '0, sec_nmi_cfg = '0;
    dcir_sec_map_s [31:0] sec_map_cfg = '0;
    int miscompares = 0, n_checks = 0, cyc = 0;

    dcir_router u_dcir_router (.core_clk, .rst_n, .src_irq, .main_prio_cfg, .main_nmi_cfg,
        .sec_map_cfg, .sec_nmi_cfg, .wake_en_cfg, .deep_sleep, .sysfn_main_req, .sysfn_sec_req,
        .sysfn_debug_access_port_req, .sysfn_done, .main_numbered_request_line, .main_prio,
        .main_nmi, .main_wakeup, .sec_numbered_request_line, .sec_prio, .sec_nmi, .sec_wakeup,
        .sysfn_busy);
    dcir_core_model u_dcir_core_model (.core_clk, .rst_n, .sec_nmi, .lat, .sysfn_done);

    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic pick(logic [146:0] v, logic [7:0] s);
        return s < 8'h93 && v[s];
    endfunction
    function automatic logic [440:0] rnd();
        logic [447:0] v;
        for (int i = 0; i < 14; i++) v[i*32+:32] = $urandom;
        return v[440:0];
    endfunction
    // selections lean on the edges: last source, first empty code, none
    function automatic logic [7:0] rsel();
        case ($urandom % 4)
            0: return 8'h92;
            1: return 8'h93;
            2: return DCIR_SEL_NONE;
            default: return 8'($urandom % 147);
        endcase
    endfunction
    task automatic check(logic [440:0] got, logic [440:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial forever #4 core_clk = ~core_clk;
    // expected outputs one edge on; done from the core model is read as the router sees it
    always @(posedge core_clk) begin
        logic st;
        st = sysfn_main_req | sysfn_sec_req | sysfn_debug_access_port_req;
        e_main <= src_irq;
        e_prio <= main_prio_cfg;
        e_mnmi <= main_nmi_cfg.enable & pick(src_irq, main_nmi_cfg.src);
        e_wake <= deep_sleep & |(src_irq[40:0] & wake_en_cfg);
        e_busy <= rst_n & (st | e_busy & !sysfn_done);
        e_snmi <= sec_nmi_cfg.enable & pick(src_irq, sec_nmi_cfg.src) | st | e_busy & !sysfn_done;
        for (int i = 0; i < 32; i++) begin
            e_sec[i] <= pick(src_irq, sec_map_cfg[i].src);
            e_sprio[i*2+:2] <= sec_map_cfg[i].prio;
        end
        live <= rst_n;
        if (++cyc > 3000) begin
            miscompares++;
            close_out();
        end
    end
    // outputs are settled at the falling edge
    always @(negedge core_clk) begin
        if (live) begin
            check(main_numbered_request_line, e_main);
            check(sec_numbered_request_line, e_sec);
            check(main_prio, e_prio);
            check(sec_prio, e_sprio);
            check(main_nmi, e_mnmi);
            check({sec_nmi, sysfn_busy}, {e_snmi, e_busy});
            check({main_wakeup, sec_wakeup}, {2{e_wake}});
        end
    end
    // random traffic with a second reset in mid-run
    initial begin
        void'($urandom(55));
        repeat (16) @(posedge core_clk);
        for (int n = 0; n < 2000; n++) begin
            @(posedge core_clk);
            rst_n <= !(n inside {[1000:1003]});
            r = rnd();
            src_irq <= r[146:0];
            wake_en_cfg <= r[440:400];
            main_prio_cfg <= rnd();
            deep_sleep <= 1'($urandom);
            main_nmi_cfg <= {1'($urandom), rsel()};
            sec_nmi_cfg <= {1'($urandom % 4 == 0), rsel()};
            for (int i = 0; i < 32; i++) sec_map_cfg[i] <= {rsel(), 2'($urandom)};
            sysfn_main_req <= $urandom % 16 == 0;
            sysfn_sec_req <= $urandom % 16 == 0;
            sysfn_debug_access_port_req <= $urandom % 16 == 0;
            lat <= 3'($urandom);
        end
        close_out();
    end
endmodule

bind dcir_router dcir_props u_dcir_props (.core_clk, .rst_n, .src_irq, .main_nmi_cfg,
    .sec_map_cfg, .sysfn_main_req, .sysfn_done, .sysfn_sec_req, .sysfn_debug_access_port_req,
    .deep_sleep, .main_numbered_request_line, .main_nmi,
    .main_wakeup, .sec_wakeup, .sec_numbered_request_line, .sec_nmi, .sysfn_busy);
